// >>> hdl/fes_error_status.sv
// Error status, count and track registers with free-format check code control behind an AXI4-Lite slave.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
// Operation
// - Set CRC error when recovered check value differs, on ID or data field.
// - ID check failure sets CRC and sector bits; data failure sets CRC only.
// - Set data-mark-missing when no valid data mark found in sector.
// - Three index pulses without matching ID during search set sector-not-found.
// - Seek-home that never sees track zero sets seek error.
// - File-inoperable bit is not stored; live input read onto bus.
// - Reading error status with file-inoperable high pulses the clear output.
// - Write-protect high during a write command sets write error.
// - Ready falling while busy sets hard error.
// - Seek loads target into general count; end copies it into current track.
// - Multi-sector count is sectors minus one, decremented per sector.
// - Check code control acts only during free-format commands.
// - Free write accumulates from next buffer-to-shifter transfer until shift bit.
// - Free read accumulates bytes read until enable clears, then checks them.
// - Shift bit sends computed check value out serially; later bytes excluded.
// - Logical track written by software is compared with each ID track byte.
// - Logical track register is never changed by command execution.
// - Clearing error status also pulses the summary-error clear.
// - Target sector register is compared with each ID sector byte.
module fes_error_status
(
	input wire logic i_clk_sys, // System clock, 125 MHz.
	input wire logic i_reset, // Synchronous reset, active high.
	input wire logic [fes_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [fes_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic i_ready, // Drive ready pin.
	input wire logic i_protect_in, // Write protect pin.
	input wire logic i_track_zero, // Track zero pin.
	input wire logic i_index, // Index pin.
	input wire logic i_file_fault_in, // File inoperable pin.
	output logic o_file_fault_clear_out, // File inoperable reset pulse.
	output logic o_write_serial_out, // Serial write data.
	input wire logic i_busy, // Sequencer executing a command.
	input wire logic i_cmd_end, // Pulse: command finished.
	input wire logic i_search_active, // Address search phase running.
	input wire logic i_id_valid, // Pulse: ID field decoded.
	input wire logic [6:0] i_id_track, // ID field track byte.
	input wire logic [4:0] i_id_sector, // ID field sector byte.
	input wire logic i_id_crc_ok, // ID field check passed.
	input wire logic i_data_crc_bad, // Pulse: data field check failed.
	input wire logic i_dmark_missing, // Pulse: no valid data mark.
	input wire logic i_xfer_error, // Pulse: buffer overrun or underflow.
	input wire logic i_sector_done, // Pulse: one sector transferred.
	input wire logic i_rx_valid, // Pulse: byte from input shifter.
	input wire logic [7:0] i_rx_byte, // Byte from input shifter.
	input wire logic i_shift_load, // Pulse: output shifter takes next byte.
	input wire logic i_bit_tick, // Enable: one serial bit time.
	output logic [7:0] o_command, // Command and masks register.
	output logic o_cmd_issue, // Pulse: command written.
	output logic o_dob_written, // Pulse: output buffer written.
	output logic o_dib_read, // Pulse: input buffer read.
	output logic o_sector_found, // Pulse: ID matched track and sector.
	output logic o_search_fail, // Pulse: search gave up.
	output logic o_summary_clear, // Pulse: clear summary error bit.
	output logic o_error_any, // Any latched error bit set.
	output logic [7:0] o_current_track, // Current head track.
	output logic [6:0] o_general_count // General count value.
);
	import fes_pkg::*;

	typedef struct packed {
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [7:0] wdata;
		logic wen;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [7:0] dob;
		logic [7:0] dib;
		logic [7:0] track;
		logic [7:0] cmd;
		logic [4:0] sector;
		logic [6:0] count;
		logic [1:0] check_code_control;
		logic [6:0] ltrack;
		logic [7:0] err;
		logic [PIN_N-1:0] sy1;
		logic [PIN_N-1:0] sy2;
		logic [PIN_N-1:0] sy3;
		logic [PIN_N-1:0] pin;
		logic [1:0] revs;
		logic tz_seen;
		logic [15:0] crc;
		logic crc_on;
		logic [15:0] osr;
		logic [4:0] osr_cnt;
		logic ffc;
		logic sumclr;
		logic issue;
		logic dob_wr;
		logic dib_rd;
		logic found;
		logic fail;
	} fes_state_t;

	fes_state_t st_ff;
	fes_state_t nxt_st;

	function automatic logic [15:0] fes_crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_write;
	logic [ADDR_W-1:0] wr_addr;
	logic [2:0] wr_idx;
	logic [7:0] wr_data;
	logic [2:0] rd_idx;
	logic err_read;
	logic [7:0] err_set;
	logic [3:0] op;
	logic free_rd;
	logic free_wr;
	logic write_cmd;

	assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
	assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
	assign s_axi_arready = !st_ff.rvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign do_write = (st_ff.aw_got || aw_hs) && (st_ff.w_got || w_hs);
	assign wr_addr = st_ff.aw_got ? st_ff.aw_addr : s_axi_awaddr;
	assign wr_idx = wr_addr[4:2];
	assign wr_data = st_ff.w_got ? st_ff.wdata : s_axi_wdata[7:0];
	assign rd_idx = s_axi_araddr[4:2];
	assign err_read = ar_hs && rd_idx == IDX_SECTOR_ERR && !s_axi_araddr[5];
	assign op = st_ff.cmd[3:0];
	// The check code control is masked for every other command.
	assign free_rd = i_busy && op == CMD_FREE_READ;
	assign free_wr = i_busy && op == CMD_FREE_WRITE;
	assign write_cmd = op == CMD_SINGLE_WRITE || op == CMD_DELETED_WRITE || op == CMD_MULTI_WRITE
		|| op == CMD_FREE_WRITE;

	always_comb
	begin
		nxt_st = st_ff;
		err_set = ERR_RESET;
		nxt_st.ffc = 1'b0;
		nxt_st.sumclr = 1'b0;
		nxt_st.issue = 1'b0;
		nxt_st.dob_wr = 1'b0;
		nxt_st.dib_rd = 1'b0;
		nxt_st.found = 1'b0;
		nxt_st.fail = 1'b0;
		// A pin change counts only once the second and third stages agree.
		nxt_st.sy1 = {i_file_fault_in, i_index, i_track_zero, i_protect_in, i_ready};
		nxt_st.sy2 = st_ff.sy1;
		nxt_st.sy3 = st_ff.sy2;
		for (int i = 0; i < PIN_N; i++)
			if (st_ff.sy2[i] == st_ff.sy3[i])
				nxt_st.pin[i] = st_ff.sy3[i];

		if (aw_hs)
		begin
			nxt_st.aw_got = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (w_hs)
		begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata[7:0];
			nxt_st.wen = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
			nxt_st.bvalid = 1'b0;
		if (s_axi_rvalid && s_axi_rready)
			nxt_st.rvalid = 1'b0;

		if (i_id_valid && !i_id_crc_ok)
		begin
			err_set[ERR_CRC] = 1'b1;
			err_set[ERR_SECTOR] = 1'b1;
		end
		if (i_data_crc_bad)
			err_set[ERR_CRC] = 1'b1;
		err_set[ERR_DMARK] = i_dmark_missing;
		err_set[ERR_XFER] = i_xfer_error;
		err_set[ERR_WRITE] = i_busy && write_cmd && st_ff.pin[PIN_PROTECT];
		err_set[ERR_HARD] = i_busy && st_ff.pin[PIN_READY] && !nxt_st.pin[PIN_READY];

		if (i_busy && st_ff.pin[PIN_TRACK0])
			nxt_st.tz_seen = 1'b1;
		// Index pulses are counted only while the sequencer searches.
		if (!i_search_active)
			nxt_st.revs = 2'h0;
		else if (i_id_valid && i_id_crc_ok && i_id_sector == st_ff.sector && i_id_track == st_ff.ltrack)
		begin
			nxt_st.found = 1'b1;
			nxt_st.revs = 2'h0;
		end
		else if (!st_ff.pin[PIN_INDEX] && nxt_st.pin[PIN_INDEX])
		begin
			if (st_ff.revs == SEARCH_REVS - 2'h1)
			begin
				err_set[ERR_SECTOR] = 1'b1;
				nxt_st.fail = 1'b1;
				nxt_st.revs = 2'h0;
			end
			else
				nxt_st.revs = st_ff.revs + 2'h1;
		end

		if (i_cmd_end && op == CMD_SEEK)
			nxt_st.track = {1'b0, st_ff.count};
		if (i_cmd_end && op == CMD_SEEK_HOME)
		begin
			err_set[ERR_SEEK] = !st_ff.tz_seen;
			nxt_st.track = st_ff.tz_seen ? 8'h00 : st_ff.track;
		end
		if (i_sector_done && (op == CMD_MULTI_READ || op == CMD_MULTI_WRITE))
			nxt_st.count = st_ff.count - 7'h01;

		if (i_rx_valid)
			nxt_st.dib = i_rx_byte;
		if (st_ff.osr_cnt != 5'h00 && i_bit_tick)
		begin
			nxt_st.osr = {st_ff.osr[14:0], 1'b0};
			nxt_st.osr_cnt = st_ff.osr_cnt - 5'h01;
		end
		if (i_shift_load)
		begin
			if (free_wr && st_ff.crc_on && st_ff.check_code_control[CCR_SHIFT])
			begin
				// Sending the check value ends accumulation for the rest of the command.
				nxt_st.osr = st_ff.crc;
				nxt_st.osr_cnt = SHIFT_CRC_BITS;
				nxt_st.crc_on = 1'b0;
			end
			else
			begin
				nxt_st.osr = {st_ff.dob, 8'h00};
				nxt_st.osr_cnt = SHIFT_BYTE_BITS;
				if (free_wr && st_ff.crc_on)
					nxt_st.crc = fes_crc_byte(st_ff.crc, st_ff.dob);
			end
		end

		if (ar_hs)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = s_axi_araddr[5] ? RESP_SLVERR : RESP_OKAY;
			nxt_st.rdata = 8'h00;
			if (!s_axi_araddr[5])
			begin
				unique case (rd_idx)
					IDX_DATA_BUF:
					begin
						nxt_st.rdata = st_ff.dib;
						nxt_st.dib_rd = 1'b1;
						if (free_rd && st_ff.crc_on)
							nxt_st.crc = fes_crc_byte(st_ff.crc, st_ff.dib);
					end
					IDX_CUR_TRACK: nxt_st.rdata = st_ff.track;
					IDX_SECTOR_ERR:
					begin
						nxt_st.rdata = st_ff.err;
						nxt_st.rdata[ERR_FILE] = st_ff.pin[PIN_FILE];
						nxt_st.ffc = st_ff.pin[PIN_FILE];
						nxt_st.sumclr = 1'b1;
					end
					default: nxt_st.rdata = 8'h00;
				endcase
			end
		end

		if (do_write)
		begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wr_addr[5] ? RESP_SLVERR : RESP_OKAY;
			if (!wr_addr[5] && (st_ff.w_got ? st_ff.wen : s_axi_wstrb[0]))
			begin
				unique case (wr_idx)
					IDX_DATA_BUF:
					begin
						nxt_st.dob = wr_data;
						nxt_st.dob_wr = 1'b1;
					end
					IDX_CUR_TRACK: nxt_st.track = wr_data;
					IDX_COMMAND:
					begin
						nxt_st.cmd = wr_data;
						nxt_st.issue = 1'b1;
						nxt_st.tz_seen = 1'b0;
					end
					IDX_SECTOR_ERR: nxt_st.sector = wr_data[4:0];
					IDX_GEN_COUNT: nxt_st.count = wr_data[6:0];
					IDX_CHECK_CTRL:
					begin
						nxt_st.check_code_control = wr_data[1:0];
						if (wr_data[CCR_ENABLE] && !st_ff.check_code_control[CCR_ENABLE])
						begin
							nxt_st.crc = CRC_INIT;
							nxt_st.crc_on = 1'b1;
						end
						else if (!wr_data[CCR_ENABLE] && st_ff.check_code_control[CCR_ENABLE])
						begin
							nxt_st.crc_on = 1'b0;
							// Check bytes were accumulated too, so a good block leaves zero.
							err_set[ERR_CRC] = err_set[ERR_CRC] || (free_rd && st_ff.crc_on
								&& st_ff.crc != 16'h0000);
						end
					end
					IDX_LOG_TRACK: nxt_st.ltrack = wr_data[6:0];
					default: nxt_st.cmd = st_ff.cmd;
				endcase
			end
		end

		// A fresh error arriving in the read cycle survives the clear.
		nxt_st.err = ((err_read ? ERR_RESET : st_ff.err) | err_set) & ~(8'h01 << ERR_FILE);
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rresp = st_ff.rresp;
	assign s_axi_rdata = {24'h000000, st_ff.rdata};
	assign o_file_fault_clear_out = st_ff.ffc;
	assign o_write_serial_out = st_ff.osr[15];
	assign o_command = st_ff.cmd;
	assign o_cmd_issue = st_ff.issue;
	assign o_dob_written = st_ff.dob_wr;
	assign o_dib_read = st_ff.dib_rd;
	assign o_sector_found = st_ff.found;
	assign o_search_fail = st_ff.fail;
	assign o_summary_clear = st_ff.sumclr;
	assign o_error_any = |st_ff.err;
	assign o_current_track = st_ff.track;
	assign o_general_count = st_ff.count;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	fi_clear_pulse_a: assert property (err_read && st_ff.pin[PIN_FILE] |=> o_file_fault_clear_out)
		else $error("file fault clear pulse missing");
	fi_live_read_a: assert property (err_read |=> s_axi_rdata[ERR_FILE] == $past(st_ff.pin[PIN_FILE]))
		else $error("file fault bit not live");
	seek_copy_a: assert property (i_cmd_end && op == CMD_SEEK |=> o_current_track == {1'b0, $past(st_ff.count)})
		else $error("seek end did not copy count");
	count_dec_a: assert property (i_sector_done && (op == CMD_MULTI_READ || op == CMD_MULTI_WRITE) && !do_write
		|=> o_general_count == $past(st_ff.count) - 7'h01)
		else $error("sector count not decremented");
	ltrack_hold_a: assert property (!(do_write && wr_idx == IDX_LOG_TRACK) |=> $stable(st_ff.ltrack))
		else $error("logical track changed by command");
	id_crc_both_a: assert property (i_id_valid && !i_id_crc_ok |=> st_ff.err[ERR_CRC] && st_ff.err[ERR_SECTOR])
		else $error("ID check failure bits wrong");
	search_fail_a: assert property (o_search_fail |-> st_ff.err[ERR_SECTOR] && $past(i_search_active))
		else $error("search fail without sector error");
	hard_err_a: assert property (i_busy && $fell(st_ff.pin[PIN_READY]) |-> st_ff.err[ERR_HARD] || $past(err_read))
		else $error("hard error not set");
	err_clear_a: assert property (err_read && err_set == ERR_RESET |=> st_ff.err == ERR_RESET ##0 o_summary_clear)
		else $error("error status clear incomplete");
endmodule

// >>> hdl/fes_pkg.sv
// Package of offsets, field positions, command codes and reset values for the error-status block.
package fes_pkg;
	localparam int ADDR_W = 6;
	// Register indices; the byte address is four times the index.
	localparam logic [2:0] IDX_DATA_BUF = 3'h0;
	localparam logic [2:0] IDX_CUR_TRACK = 3'h1;
	localparam logic [2:0] IDX_COMMAND = 3'h2;
	localparam logic [2:0] IDX_SECTOR_ERR = 3'h4;
	localparam logic [2:0] IDX_GEN_COUNT = 3'h5;
	localparam logic [2:0] IDX_CHECK_CTRL = 3'h6;
	localparam logic [2:0] IDX_LOG_TRACK = 3'h7;
	// Error status bit positions.
	localparam int ERR_XFER = 0;
	localparam int ERR_CRC = 1;
	localparam int ERR_DMARK = 2;
	localparam int ERR_SECTOR = 3;
	localparam int ERR_SEEK = 4;
	localparam int ERR_FILE = 5;
	localparam int ERR_WRITE = 6;
	localparam int ERR_HARD = 7;
	// Check code control bit positions.
	localparam int CCR_ENABLE = 0;
	localparam int CCR_SHIFT = 1;
	// Drive pin positions in the synchroniser vector.
	localparam int PIN_READY = 0;
	localparam int PIN_PROTECT = 1;
	localparam int PIN_TRACK0 = 2;
	localparam int PIN_INDEX = 3;
	localparam int PIN_FILE = 4;
	localparam int PIN_N = 5;
	// Macro command codes in the low nibble of the command register.
	localparam logic [3:0] CMD_SEEK_HOME = 4'h2;
	localparam logic [3:0] CMD_SEEK = 4'h3;
	localparam logic [3:0] CMD_SINGLE_WRITE = 4'h5;
	localparam logic [3:0] CMD_DELETED_WRITE = 4'h7;
	localparam logic [3:0] CMD_FREE_READ = 4'ha;
	localparam logic [3:0] CMD_FREE_WRITE = 4'hb;
	localparam logic [3:0] CMD_MULTI_READ = 4'hc;
	localparam logic [3:0] CMD_MULTI_WRITE = 4'hd;
	// Search gives up after this many index pulses.
	localparam logic [1:0] SEARCH_REVS = 2'h3;
	// Check code polynomial x16+x12+x5+1, preset to all ones.
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [4:0] SHIFT_BYTE_BITS = 5'h08;
	localparam logic [4:0] SHIFT_CRC_BITS = 5'h10;
endpackage

// >>> sim/fes_drive_model.sv
// Floppy drive model: pin levels set by the bench and one index pulse per revolution.
`timescale 1ns/10ps
module fes_drive_model
#(
	parameter int REV = 40
)
(
	input wire logic i_clk_sys, // Clock.
	input wire logic i_spin, // Disk turning.
	input wire logic [3:0] i_lvl, // Ready, protect, track zero, fault.
	output logic o_ready, // Ready pin.
	output logic o_protect_in, // Write protect pin.
	output logic o_track_zero, // Track zero pin.
	output logic o_index, // Index pin.
	output logic o_file_fault_in // File fault pin.
);
	int cnt_ff = 0;
	assign o_ready = i_lvl[0];
	assign o_protect_in = i_lvl[1];
	assign o_track_zero = i_lvl[2];
	assign o_file_fault_in = i_lvl[3];
	// The pulse spans four clocks so that the pin synchroniser cannot miss it.
	assign o_index = i_spin && cnt_ff < 4;
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_spin || cnt_ff == REV - 1)
			cnt_ff <= 0;
		else
			cnt_ff <= cnt_ff + 1;
	end
endmodule

// >>> sim/test_fdc_error_status_and_crc_control.sv
// Self-checking bench for the error status and check code control block.
`timescale 1ns/10ps
module test_fdc_error_status_and_crc_control import fes_pkg::*;;
	localparam int REV = 40;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [5:0] awaddr = 6'h00;
	logic [5:0] araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, rdy, prot, tz, idx, ff, fclr, sout, found, fail, sclr;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic busy = 1'h0, srch = 1'h0, crc_ok = 1'h1, spin = 1'h0;
	logic [3:0] lvl = 4'h1;
	logic [8:0] pv = 9'h000;
	logic [6:0] idt = 7'h00, gcnt;
	logic [4:0] ids = 5'h00;
	logic [7:0] rxb = 8'h00, ctrk, v, s, t, ocmd;
	logic ci, dw, dr, eany;
	logic [15:0] c;
	logic [31:0] sd = 32'hb5cc;
	int num_errors = 0, samples_checked = 0, nfc = 0, nsum = 0, nfd = 0, nfl = 0, n;
	int nci = 0, ndw = 0, ndr = 0;

	fes_drive_model #(.REV(REV)) drive (.i_clk_sys(clk), .i_spin(spin), .i_lvl(lvl), .o_ready(rdy),
		.o_protect_in(prot), .o_track_zero(tz), .o_index(idx), .o_file_fault_in(ff));
	fes_error_status dut (.i_clk_sys(clk), .i_reset(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .i_ready(rdy),
		.i_protect_in(prot), .i_track_zero(tz), .i_index(idx), .i_file_fault_in(ff),
		.o_file_fault_clear_out(fclr), .o_write_serial_out(sout), .i_busy(busy), .i_cmd_end(pv[0]),
		.i_search_active(srch), .i_id_valid(pv[1]), .i_id_track(idt), .i_id_sector(ids), .i_id_crc_ok(crc_ok),
		.i_data_crc_bad(pv[2]), .i_dmark_missing(pv[3]), .i_xfer_error(pv[4]), .i_sector_done(pv[5]),
		.i_rx_valid(pv[6]), .i_rx_byte(rxb), .i_shift_load(pv[7]), .i_bit_tick(pv[8]), .o_command(ocmd),
		.o_cmd_issue(ci), .o_dob_written(dw), .o_dib_read(dr), .o_sector_found(found), .o_search_fail(fail),
		.o_summary_clear(sclr), .o_error_any(eany), .o_current_track(ctrk), .o_general_count(gcnt));

	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		nfc <= nfc + int'(fclr);
		nsum <= nsum + int'(sclr);
		nfd <= nfd + int'(found);
		nfl <= nfl + int'(fail);
		nci <= nci + int'(ci);
		ndw <= ndw + int'(dw);
		ndr <= ndr + int'(dr);
	end

	task close_out();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task hang();
		num_errors++;
		$display("unexpected at %0t: no bus response", $time);
		close_out();
	endtask

	function logic [7:0] rnd();
		sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
		return sd[7:0];
	endfunction

	// Reference check code, most significant bit first.
	function logic [15:0] crc(input logic [15:0] x, input logic [7:0] b);
		logic fb;
		for (int i = 7; i >= 0; i--)
		begin
			fb = x[15] ^ b[i];
			x = {x[14:0], 1'h0};
			if (fb)
				x = x ^ CRC_POLY;
		end
		return x;
	endfunction

	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task pul(input int k);
		pv[k] <= 1'h1;
		@(posedge clk);
		pv <= 9'h000;
		@(posedge clk);
	endtask

	// Address and data are offered together and each is dropped once taken.
	task wr(input logic [5:0] a, input logic [7:0] x);
		int i;
		awaddr <= a;
		wdata <= {24'h000000, x};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		i = 0;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
			i++;
		end
		while (!bvalid && i < 40);
		if (!bvalid)
			hang();
		r = bresp;
		bready <= 1'h0;
		@(posedge clk);
	endtask

	task rd(input logic [5:0] a);
		int i;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		i = 0;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'h0;
			i++;
		end
		while (!rvalid && i < 40);
		if (!rvalid)
			hang();
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		@(posedge clk);
	endtask

	task rs(input logic [7:0] e);
		rd(6'h10);
		chk(d, {24'h000000, e});
	endtask

	task cmd(input logic [3:0] k);
		busy <= 1'h1;
		wr(6'h08, {4'h0, k});
	endtask

	task ser(input logic [15:0] x, input int nb);
		for (int i = nb - 1; i >= 0; i--)
		begin
			chk({31'h0, sout}, {31'h0, x[i]});
			pul(8);
		end
	endtask

	initial
	begin
		cyc(5);
		rst <= 1'h0;
		cyc(2);
		rs(8'h00);
		wr(6'h20, 8'h11);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(6'h24);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		v = rnd();
		wr(6'h04, v);
		rd(6'h04);
		chk(d, {24'h000000, v});
		// A write with its low byte lane disabled must leave the register alone.
		wstrb <= 4'h0;
		wr(6'h04, ~v);
		wstrb <= 4'hf;
		rd(6'h04);
		chk(d, {24'h000000, v});
		s = rnd() & 8'h1f;
		t = rnd() & 8'h7f;
		wr(6'h10, s);
		wr(6'h1c, t);
		$display("test map done");
		for (int k = 2; k < 5; k++)
		begin
			n = nsum;
			pul(k);
			chk(eany, 1);
			rs(k == 2 ? 8'h02 : k == 3 ? 8'h04 : 8'h01);
			chk(nsum, n + 1);
			rs(8'h00);
			chk(eany, 0);
		end
		crc_ok <= 1'h0;
		pul(1);
		crc_ok <= 1'h1;
		rs(8'h0a);
		lvl[3] <= 1'h1;
		cyc(8);
		n = nfc;
		rs(8'h20);
		chk(nfc, n + 1);
		lvl[3] <= 1'h0;
		cyc(8);
		rs(8'h00);
		chk(nfc, n + 1);
		$display("test flags done");
		cmd(CMD_SEEK_HOME);
		pul(0);
		busy <= 1'h0;
		rs(8'h10);
		cmd(CMD_SINGLE_WRITE);
		lvl[1] <= 1'h1;
		cyc(8);
		lvl[1] <= 1'h0;
		cyc(6);
		busy <= 1'h0;
		rs(8'h40);
		cmd(CMD_SEEK);
		lvl[0] <= 1'h0;
		cyc(8);
		busy <= 1'h0;
		lvl[0] <= 1'h1;
		cyc(6);
		rs(8'h80);
		v = rnd() & 8'h7f;
		wr(6'h14, v);
		cmd(CMD_SEEK);
		pul(0);
		busy <= 1'h0;
		chk(ctrk, v);
		wr(6'h14, 8'h05);
		n = nci;
		cmd(CMD_MULTI_WRITE);
		chk(nci, n + 1);
		chk(ocmd, {4'h0, CMD_MULTI_WRITE});
		for (int i = 0; i < 3; i++)
		begin
			pul(5);
			chk(gcnt, 4 - i);
		end
		busy <= 1'h0;
		$display("test commands done");
		srch <= 1'h1;
		idt <= t[6:0];
		ids <= s[4:0] ^ 5'h01;
		n = nfd;
		pul(1);
		cyc(1);
		chk(nfd, n);
		idt <= t[6:0] ^ 7'h01;
		ids <= s[4:0];
		pul(1);
		cyc(1);
		chk(nfd, n);
		idt <= t[6:0];
		pul(1);
		cyc(1);
		chk(nfd, n + 1);
		spin <= 1'h1;
		cyc(2 * REV + 10);
		spin <= 1'h0;
		cyc(6);
		chk(nfl, 1);
		srch <= 1'h0;
		rs(8'h08);
		$display("test search done");
		cmd(CMD_SINGLE_WRITE);
		wr(6'h18, 8'h03);
		v = rnd();
		wr(6'h00, v);
		pul(7);
		ser({8'h00, v}, 8);
		wr(6'h18, 8'h00);
		cmd(CMD_FREE_WRITE);
		wr(6'h18, 8'h01);
		c = CRC_INIT;
		repeat (2)
		begin
			v = rnd();
			c = crc(c, v);
			n = ndw;
			wr(6'h00, v);
			chk(ndw, n + 1);
			pul(7);
			ser({8'h00, v}, 8);
		end
		wr(6'h18, 8'h03);
		pul(7);
		ser(c, 16);
		wr(6'h18, 8'h00);
		busy <= 1'h0;
		for (int k = 0; k < 2; k++)
		begin
			cmd(CMD_FREE_READ);
			wr(6'h18, 8'h01);
			c = CRC_INIT;
			for (int i = 0; i < 4; i++)
			begin
				v = i == 2 ? c[15:8] : c[7:0] ^ 8'(k);
				if (i < 2)
					v = rnd();
				if (i < 2)
					c = crc(c, v);
				rxb <= v;
				pul(6);
				n = ndr;
				rd(6'h00);
				chk(d, {24'h000000, v});
				chk(ndr, n + 1);
			end
			wr(6'h18, 8'h00);
			busy <= 1'h0;
			rs(k == 1 ? 8'h02 : 8'h00);
		end
		$display("test check code done");
		// A reset in mid-run must drop latched error bits just as a read does.
		pul(2);
		chk(eany, 1);
		rst <= 1'h1;
		cyc(2);
		rst <= 1'h0;
		cyc(2);
		chk(eany, 0);
		rs(8'h00);
		$display("test reset done");
		close_out();
	end
endmodule
